// ==== verilog/opsel_defines.vh ====
`ifndef OPSEL_DEFINES_VH
`define OPSEL_DEFINES_VH
// ----------------------------------------------------------------
// register offsets (4-bit address)
// ----------------------------------------------------------------
`define OPSEL_ADDR_AUX_CONTROL 4'h4
`define OPSEL_ADDR_IRQ_STATUS 4'h5
`define OPSEL_ADDR_PRESET_HI 4'h6
`define OPSEL_ADDR_PRESET_LO 4'h7
`define OPSEL_ADDR_OUT_SELECT 4'hD
`define OPSEL_ADDR_BIT_SET 4'hE
`define OPSEL_ADDR_BIT_CLEAR 4'hF
`define OPSEL_ADDR_LATCH_RD 4'hB
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define OPSEL_AUX_BAUD_SET 7
`define OPSEL_AUX_MODE_HI 6
`define OPSEL_AUX_MODE_LO 4
`define OPSEL_IRQ_INPUT_CHANGE 7
`define OPSEL_IRQ_COUNTER_READY 3
`define OPSEL_IRQ_RX 1
`define OPSEL_IRQ_TX 0
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define OPSEL_RST_BYTE 8'h00
`define OPSEL_RST_PRESET 16'h0002
// ----------------------------------------------------------------
// select codes and mode codes
// ----------------------------------------------------------------
`define OPSEL_P3_LATCH 2'h0
`define OPSEL_P3_CT 2'h1
`define OPSEL_P2_LATCH 2'h0
`define OPSEL_P2_TX16 2'h1
`define OPSEL_P2_TX1 2'h2
`define OPSEL_P2_RX1 2'h3
`define OPSEL_CT_CNT_IN2 3'h0
`define OPSEL_CT_CNT_TX1 3'h1
`define OPSEL_CT_CNT_XD16 3'h3
`define OPSEL_CT_TMR_IN2 3'h4
`define OPSEL_CT_TMR_IN2D16 3'h5
`define OPSEL_CT_TMR_X 3'h6
`define OPSEL_CT_TMR_XD16 3'h7
// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define OPSEL_PRESCALE 4'hF
`endif

// ==== verilog/opsel_sync.v ====
`timescale 1ns/100ps
// two-stage synchroniser, one per bit
module opsel_sync #(
  parameter WIDTH = 4
) (
  input wire i_ref_clk,
  input wire i_nrst,
  input wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;
  always @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end
  assign o_sync = sync_r;
endmodule // opsel_sync

// ==== verilog/opsel_ctr.v ====
`timescale 1ns/100ps
`include "opsel_defines.vh"
// counter/timer output generator
module opsel_ctr (
  input wire i_ref_clk,
  input wire i_nrst,
  input wire [2:0] i_mode,
  input wire [15:0] i_preset,
  input wire i_tick_in2,
  input wire i_tick_tx1,
  input wire i_start,
  input wire i_stop,
  output reg o_ct_out,
  output reg o_ready
);
  reg [15:0] count_r;
  reg run_r;
  reg [3:0] pre_r;
  reg tick;
  reg half_r;
  wire timer_mode;
  wire pre_hit;
  assign timer_mode = i_mode[2];
  assign pre_hit = (pre_r == `OPSEL_PRESCALE);
  // ----------------------------------------------------------------
  // clock source selection
  // ----------------------------------------------------------------
  always @*
  begin
    case (i_mode)
      `OPSEL_CT_CNT_IN2: tick = i_tick_in2;
      `OPSEL_CT_CNT_TX1: tick = i_tick_tx1;
      `OPSEL_CT_CNT_XD16: tick = pre_hit;
      `OPSEL_CT_TMR_IN2: tick = i_tick_in2;
      `OPSEL_CT_TMR_IN2D16: tick = i_tick_in2 & pre_hit;
      `OPSEL_CT_TMR_X: tick = 1'b1;
      `OPSEL_CT_TMR_XD16: tick = pre_hit;
      default: tick = 1'b0;
    endcase
  end
  always @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      count_r <= 16'h0000;
      run_r <= 1'b0;
      pre_r <= 4'h0;
      half_r <= 1'b0;
      o_ct_out <= 1'b1;
      o_ready <= 1'b0;
    end
    else
    begin
      if (i_mode == `OPSEL_CT_TMR_IN2D16)
      begin
        if (i_tick_in2)
          pre_r <= pre_r + 4'h1;
      end
      else
        pre_r <= pre_r + 4'h1;
      if (i_start)
      begin
        run_r <= 1'b1;
        count_r <= i_preset;
        half_r <= 1'b0;
        o_ct_out <= 1'b1;
      end
      else
      begin
        // stop clears ready; in timer mode a ready event in the same cycle wins
        if (i_stop)
          o_ready <= 1'b0;
        // timer keeps counting through a stop command
        if (i_stop && !timer_mode)
        begin
          run_r <= 1'b0;
          o_ct_out <= 1'b1;
        end
        else if (run_r && tick)
        begin
          if (count_r <= 16'h0001)
          begin
            count_r <= i_preset;
            if (timer_mode)
            begin
              o_ct_out <= ~o_ct_out;
              half_r <= ~half_r;
              if (half_r)
                o_ready <= 1'b1;
            end
            else
            begin
              o_ct_out <= 1'b0;
              o_ready <= 1'b1;
            end
          end
          else
            count_r <= count_r - 16'h0001;
        end
      end
    end
  end
endmodule // opsel_ctr

// ==== verilog/opsel_port.v ====
`timescale 1ns/100ps
`include "opsel_defines.vh"
module opsel_port (
  input wire i_ref_clk,
  input wire i_nrst,
  input wire [3:0] i_addr,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  input wire [3:0] i_in_pins,
  input wire i_tx_irq,
  input wire i_rx_irq,
  input wire i_break_irq,
  input wire [7:0] i_irq_mask,
  input wire i_tx_clk16,
  input wire i_tx_clk1,
  input wire i_rx_clk1,
  input wire i_ct_start,
  input wire i_ct_stop,
  output reg [7:0] o_out_pins,
  output reg [7:0] o_out_pins_oe_n,
  output reg o_baud_set,
  output reg o_irq_out_n
);
  reg [7:0] output_latch_r;
  reg [7:0] output_pin_select_r;
  reg [7:0] aux_control_r;
  reg [3:0] change_r;
  reg [3:0] prev_r;
  reg change_irq_r;
  reg [15:0] preset_r;
  reg [7:0] pins_nxt;
  reg [7:0] oe_nxt;
  reg tx1_d_r;
  reg [1:0] warm_r;
  wire [3:0] in_sync;
  wire [3:0] edge_hit;
  wire rd_change;
  wire ct_out;
  wire ct_ready;
  wire [7:0] irq_status;
  // ----------------------------------------------------------------
  // input sampling and change detection
  // ----------------------------------------------------------------
  opsel_sync #(
    .WIDTH(4)
  ) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_async(i_in_pins),
    .o_sync(in_sync)
  );
  // no change seen until sync and previous level hold real pin levels,
  // so a pin idling high gives no false change after reset
  assign edge_hit = (warm_r == 2'h3) ? (in_sync ^ prev_r) : 4'h0;
  assign rd_change = i_rd && (i_addr == `OPSEL_ADDR_AUX_CONTROL);
  // ----------------------------------------------------------------
  // counter/timer
  // ----------------------------------------------------------------
  opsel_ctr u_ctr (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_mode(aux_control_r[`OPSEL_AUX_MODE_HI:`OPSEL_AUX_MODE_LO]),
    .i_preset(preset_r),
    .i_tick_in2(edge_hit[2] & in_sync[2]),
    .i_tick_tx1(i_tx_clk1 & ~tx1_d_r),
    .i_start(i_ct_start),
    .i_stop(i_ct_stop),
    .o_ct_out(ct_out),
    .o_ready(ct_ready)
  );
  assign irq_status = {change_irq_r, 3'h0, ct_ready, i_break_irq, i_rx_irq, i_tx_irq};
  // ----------------------------------------------------------------
  // register writes and flags
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      output_latch_r <= `OPSEL_RST_BYTE;
      output_pin_select_r <= `OPSEL_RST_BYTE;
      aux_control_r <= `OPSEL_RST_BYTE;
      preset_r <= `OPSEL_RST_PRESET;
      change_r <= 4'h0;
      prev_r <= 4'h0;
      change_irq_r <= 1'b0;
      tx1_d_r <= 1'b0;
      warm_r <= 2'h0;
    end
    else
    begin
      prev_r <= in_sync;
      tx1_d_r <= i_tx_clk1;
      if (warm_r != 2'h3)
        warm_r <= warm_r + 2'h1;
      if (i_wr)
      begin
        case (i_addr)
          `OPSEL_ADDR_AUX_CONTROL: aux_control_r <= i_wdata;
          `OPSEL_ADDR_OUT_SELECT: output_pin_select_r <= i_wdata;
          `OPSEL_ADDR_PRESET_HI: preset_r[15:8] <= i_wdata;
          `OPSEL_ADDR_PRESET_LO: preset_r[7:0] <= i_wdata;
          `OPSEL_ADDR_BIT_SET: output_latch_r <= output_latch_r | i_wdata;
          `OPSEL_ADDR_BIT_CLEAR: output_latch_r <= output_latch_r & ~i_wdata;
          default: output_latch_r <= output_latch_r;
        endcase
      end
      // new change wins over read clear
      change_r <= (rd_change ? 4'h0 : change_r) | edge_hit;
      change_irq_r <= (rd_change ? 1'b0 : change_irq_r)
        | (|(edge_hit & aux_control_r[3:0]));
    end
  end
  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_rdata <= 8'h00;
    else if (i_rd)
    begin
      case (i_addr)
        `OPSEL_ADDR_AUX_CONTROL: o_rdata <= {change_r, in_sync};
        `OPSEL_ADDR_IRQ_STATUS: o_rdata <= irq_status;
        `OPSEL_ADDR_OUT_SELECT: o_rdata <= output_pin_select_r;
        `OPSEL_ADDR_LATCH_RD: o_rdata <= output_latch_r;
        default: o_rdata <= 8'h00;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // output pin routing
  // ----------------------------------------------------------------
  always @*
  begin
    pins_nxt = ~output_latch_r;
    oe_nxt = 8'h00;
    if (output_pin_select_r[6])
    begin
      pins_nxt[6] = 1'b0;
      oe_nxt[6] = ~i_tx_irq;
    end
    if (output_pin_select_r[4])
    begin
      pins_nxt[4] = 1'b0;
      oe_nxt[4] = ~i_rx_irq;
    end
    case (output_pin_select_r[3:2])
      `OPSEL_P3_CT:
      begin
        pins_nxt[3] = 1'b0;
        oe_nxt[3] = ct_out;
      end
      default: pins_nxt[3] = ~output_latch_r[3];
    endcase
    case (output_pin_select_r[1:0])
      `OPSEL_P2_TX16: pins_nxt[2] = i_tx_clk16;
      `OPSEL_P2_TX1: pins_nxt[2] = i_tx_clk1;
      `OPSEL_P2_RX1: pins_nxt[2] = i_rx_clk1;
      default: pins_nxt[2] = ~output_latch_r[2];
    endcase
  end
  always @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_out_pins <= 8'hFF;
      o_out_pins_oe_n <= 8'h00;
      o_baud_set <= 1'b0;
      o_irq_out_n <= 1'b1;
    end
    else
    begin
      o_out_pins <= pins_nxt;
      o_out_pins_oe_n <= oe_nxt;
      o_baud_set <= aux_control_r[`OPSEL_AUX_BAUD_SET];
      o_irq_out_n <= ~(|(irq_status & i_irq_mask));
    end
  end
endmodule // opsel_port

// ==== tb/opsel_port_props.sv ====
`timescale 1ns/100ps
module opsel_port_props (
  input wire i_ref_clk,
  input wire i_nrst,
  input wire [3:0] i_addr,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] i_wdata,
  input wire [7:0] o_rdata,
  input wire [3:0] i_in_pins,
  input wire i_tx_irq,
  input wire [7:0] i_irq_mask,
  input wire [7:0] o_out_pins,
  input wire [7:0] o_out_pins_oe_n,
  input wire o_baud_set,
  input wire o_irq_out_n
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  a_clr_pin7:
    assert property (i_wr && i_addr == 4'hF && i_wdata[7] |-> ##2 o_out_pins[7])
      else $error("pin 7 not high after clear");
  a_set_pin0:
    assert property (i_wr && i_addr == 4'hE && i_wdata[0] |-> ##2 !o_out_pins[0])
      else $error("pin 0 not low after set");
  a_latch_pins_driven:
    assert property ((o_out_pins_oe_n & 8'hA7) == 8'h00)
      else $error("latch-only pin released");
  a_irq_masked:
    assert property ((i_tx_irq && i_irq_mask[0]) [*4] |-> !o_irq_out_n)
      else $error("irq output not asserted");
  a_irq_needs_mask:
    assert property (!o_irq_out_n |-> $past(i_irq_mask) != 8'h00 || $past(i_irq_mask, 2) != 8'h00)
      else $error("irq output with all masks off");
  a_baud_write:
    assert property (i_wr && i_addr == 4'h4 |-> ##2 o_baud_set == $past(i_wdata[7], 2))
      else $error("baud set bit wrong");
  a_rdata_hold:
    assert property (!i_rd |=> $stable(o_rdata))
      else $error("read data changed without read");
  a_live_level:
    assert property ($stable(i_in_pins) [*4] ##0 (i_rd && i_addr == 4'h4)
      |=> o_rdata[3:0] == $past(i_in_pins))
      else $error("live input levels wrong");
endmodule // opsel_port_props
bind opsel_port opsel_port_props props_u (.i_ref_clk, .i_nrst, .i_addr, .i_wr, .i_rd,
  .i_wdata, .o_rdata, .i_in_pins, .i_tx_irq, .i_irq_mask, .o_out_pins, .o_out_pins_oe_n,
  .o_baud_set, .o_irq_out_n);

// ==== tb/opsel_far.sv ====
`timescale 1ns/100ps
// far-side clock sources for pin 2
module opsel_far (
  input wire i_ref_clk,
  input wire i_nrst,
  output wire o_tx16,
  output wire o_tx1,
  output wire o_rx1
);
  reg [3:0] cnt_r;
  always @(posedge i_ref_clk or negedge i_nrst)
    if (!i_nrst)
      cnt_r <= 4'h0;
    else
      cnt_r <= cnt_r + 4'h1;
  // free-running, distinct rates
  assign o_tx16 = cnt_r[0];
  assign o_tx1 = cnt_r[2];
  assign o_rx1 = cnt_r[3];
endmodule // opsel_far

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
module testbench;
  reg i_ref_clk = 1'b0;
  reg i_nrst = 1'b0;
  reg [3:0] i_addr = 4'h0;
  reg i_wr = 1'b0;
  reg i_rd = 1'b0;
  reg [7:0] i_wdata = 8'h00;
  reg [3:0] i_in_pins = 4'h0;
  reg i_tx_irq = 1'b0;
  reg i_rx_irq = 1'b0;
  reg i_break_irq = 1'b0;
  reg [7:0] i_irq_mask = 8'h00;
  reg i_ct_start = 1'b0;
  reg i_ct_stop = 1'b0;
  wire [7:0] o_rdata, o_out_pins, o_out_pins_oe_n;
  wire o_baud_set, o_irq_out_n, tx16, tx1, rx1;
  integer fails = 0;
  integer n_checks = 0;
  integer cycles = 0;
  integer c;
  reg [7:0] rv;
  opsel_port dut_u (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wr(i_wr),
    .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_in_pins(i_in_pins),
    .i_tx_irq(i_tx_irq), .i_rx_irq(i_rx_irq), .i_break_irq(i_break_irq),
    .i_irq_mask(i_irq_mask),
    .i_tx_clk16(tx16), .i_tx_clk1(tx1), .i_rx_clk1(rx1), .i_ct_start(i_ct_start),
    .i_ct_stop(i_ct_stop), .o_out_pins(o_out_pins), .o_out_pins_oe_n(o_out_pins_oe_n),
    .o_baud_set(o_baud_set), .o_irq_out_n(o_irq_out_n));
  opsel_far far_u (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .o_tx16(tx16), .o_tx1(tx1),
    .o_rx1(rx1));
  initial
    forever #25 i_ref_clk = ~i_ref_clk;
  task cyc(input integer n);
    begin
      repeat (n) @(posedge i_ref_clk);
      #1;
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      i_addr = a;
      i_wdata = d;
      i_wr = 1'b1;
      cyc(1);
      i_wr = 1'b0;
      cyc(1);
    end
  endtask
  task rd(input [3:0] a);
    begin
      i_addr = a;
      i_rd = 1'b1;
      cyc(1);
      i_rd = 1'b0;
      cyc(1);
      rv = o_rdata;
    end
  endtask
  task pulse(input start);
    begin
      i_ct_start = start;
      i_ct_stop = !start;
      cyc(1);
      i_ct_start = 1'b0;
      i_ct_stop = 1'b0;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
        fails = fails + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // toggles of pin 2 (w=0) or pin 3 enable (w=1)
  task cnt_tg(input integer n, input w);
    reg p;
    integer k;
    begin
      rv = 8'h00;
      for (k = 0; k < n; k = k + 1)
      begin
        p = w ? o_out_pins_oe_n[3] : o_out_pins[2];
        cyc(1);
        if (p !== (w ? o_out_pins_oe_n[3] : o_out_pins[2]))
          rv = rv + 8'h01;
      end
    end
  endtask
  task t_latch;
    begin
      chk(o_out_pins, 8'hFF);
      wr(4'hE, 8'hA5);
      cyc(1);
      chk(o_out_pins, 8'h5A);
      wr(4'hF, 8'hA1);
      cyc(1);
      chk(o_out_pins, 8'hFB);
      rd(4'hB);
      chk(rv, 8'h04);
      $display("test latch done");
    end
  endtask
  task t_irq_pins;
    begin
      wr(4'hD, 8'h50);
      i_tx_irq = 1'b1;
      cyc(4);
      chk(o_out_pins_oe_n & 8'h50, 8'h10);
      chk({7'h00, o_out_pins[6]}, 8'h00);
      chk({7'h00, o_irq_out_n}, 8'h01);
      i_irq_mask = 8'h01;
      cyc(4);
      chk({7'h00, o_irq_out_n}, 8'h00);
      i_irq_mask = 8'h00;
      i_tx_irq = 1'b0;
      i_rx_irq = 1'b1;
      cyc(4);
      chk(o_out_pins_oe_n & 8'h50, 8'h40);
      i_rx_irq = 1'b0;
      i_break_irq = 1'b1;
      i_irq_mask = 8'h04;
      cyc(4);
      chk({7'h00, o_irq_out_n}, 8'h00);
      rd(4'h5);
      chk(rv, 8'h04);
      i_irq_mask = 8'h00;
      cyc(4);
      chk({7'h00, o_irq_out_n}, 8'h01);
      i_break_irq = 1'b0;
      $display("test irq pins done");
    end
  endtask
  task t_pin2;
    begin
      for (c = 0; c < 4; c = c + 1)
      begin
        wr(4'hD, c[7:0]);
        cyc(4);
        cnt_tg(64, 1'b0);
        chk(rv, (c == 0) ? 8'h00 : (c == 1) ? 8'h40 : (c == 2) ? 8'h10 : 8'h08);
      end
      $display("test pin2 done");
    end
  endtask
  task t_ct;
    begin
      wr(4'hD, 8'h04);
      wr(4'h4, 8'h30);
      cyc(2);
      chk({7'h00, o_out_pins_oe_n[3]}, 8'h01);
      pulse(1'b1);
      c = 0;
      while (o_out_pins_oe_n[3] !== 1'b0 && c < 200)
      begin
        cyc(1);
        c = c + 1;
      end
      chk({6'h00, c > 16, c < 200}, 8'h03);
      pulse(1'b0);
      cyc(3);
      chk({7'h00, o_out_pins_oe_n[3]}, 8'h01);
      wr(4'h4, 8'h60);
      pulse(1'b1);
      cyc(4);
      cnt_tg(40, 1'b1);
      chk(rv, 8'h14);
      wr(4'h6, 8'h00);
      wr(4'h7, 8'h05);
      pulse(1'b1);
      cyc(4);
      cnt_tg(40, 1'b1);
      chk(rv, 8'h08);
      wr(4'h4, 8'h70);
      pulse(1'b1);
      cyc(4);
      cnt_tg(160, 1'b1);
      chk(rv, 8'h02);
      wr(4'h4, 8'h10);
      wr(4'h7, 8'h02);
      pulse(1'b0);
      cyc(2);
      chk({7'h00, o_out_pins_oe_n[3]}, 8'h01);
      pulse(1'b1);
      cyc(20);
      chk({7'h00, o_out_pins_oe_n[3]}, 8'h00);
      wr(4'h4, 8'h00);
      pulse(1'b0);
      cyc(1);
      pulse(1'b1);
      i_in_pins = 4'h4;
      cyc(4);
      i_in_pins = 4'h0;
      cyc(4);
      chk({7'h00, o_out_pins_oe_n[3]}, 8'h01);
      i_in_pins = 4'h4;
      cyc(6);
      chk({7'h00, o_out_pins_oe_n[3]}, 8'h00);
      i_in_pins = 4'h0;
      pulse(1'b0);
      cyc(4);
      $display("test counter done");
    end
  endtask
  task t_inchg;
    begin
      wr(4'h4, 8'h82);
      chk({7'h00, o_baud_set}, 8'h01);
      i_irq_mask = 8'h80;
      i_in_pins = 4'h4;
      cyc(6);
      chk({7'h00, o_irq_out_n}, 8'h01);
      i_in_pins = 4'h6;
      cyc(6);
      chk({7'h00, o_irq_out_n}, 8'h00);
      rd(4'h4);
      chk(rv, 8'h66);
      cyc(2);
      chk({7'h00, o_irq_out_n}, 8'h01);
      rd(4'h4);
      chk(rv, 8'h06);
      i_irq_mask = 8'h00;
      $display("test input change done");
    end
  endtask
  task give_verdict;
    begin
      $display("checks=%0d fails=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  always @(posedge i_ref_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 5000)
    begin
      fails = fails + 1;
      give_verdict;
    end
  end
  initial
  begin
    repeat (12) @(posedge i_ref_clk);
    #1;
    i_nrst = 1'b1;
    cyc(1);
    t_latch;
    t_irq_pins;
    t_pin2;
    t_ct;
    t_inchg;
    give_verdict;
  end
endmodule // testbench
